// File: relay_input_mapping_reset_tb.sv
`timescale 1ns/1ns
`default_nettype none
module relay_input_mapping_reset_tb;
  logic core_clk_in;
  logic sys_rst_in;
  logic rst_n;
  logic [2:0] pins;
  logic [rim_pkg::ADDR_W-1:0] addr;
  logic [rim_pkg::DATA_W-1:0] wdat;
  logic wr;
  logic rd;
  logic [rim_pkg::DATA_W-1:0] rdat;
  logic [rim_pkg::CH_COUNT-1:0] sw;
  int n_fail;
  int n_tests;
  rim_top i_dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .rst_n_in(rst_n), .direct_input_ch0_in(pins[0]),
    .direct_input_ch2_in(pins[1]), .mappable_input_in(pins[2]),
    .addr_in(addr), .wr_data_in(wdat), .wr_in(wr), .rd_in(rd),
    .rd_data_out(rdat), .switch_output_out(sw));
  rim_host_model i_host (.core_clk_in(core_clk_in), .rst_n_out(rst_n),
    .pins_out(pins));
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1;
    n_tests++;
    if (rdat !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t read %h got %h", $time, a, rdat);
    end
    // Read data stand for one cycle only
    @(posedge core_clk_in);
    #1;
    n_tests++;
    if (rdat !== rim_pkg::READ_IDLE) begin
      n_fail++;
      $display("CHECK FAILED %0t read %h not idle %h", $time, a, rdat);
    end
  endtask
  task automatic chk_out(input logic r, input logic [2:0] p,
                         input logic [7:0] exp);
    i_host.drive(r, p);
    repeat (2) @(posedge core_clk_in);
    #1;
    n_tests++;
    if (sw !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t outputs %h want %h", $time, sw, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    sys_rst_in = 1'b1;
    addr = 4'h0;
    wdat = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    chk_rd(rim_pkg::ON_ADDR, 8'h00);
    chk_rd(rim_pkg::INMAP_ADDR, 8'h08);
    chk_rd(rim_pkg::REMAP_ADDR, 8'h00);
    chk_rd(4'hF, 8'h00);
    chk_out(1'b1, 3'h4, 8'h08);
    chk_out(1'b1, 3'h1, 8'h01);
    chk_out(1'b1, 3'h2, 8'h04);
    wr_reg(rim_pkg::REMAP_ADDR, 8'h03);
    chk_out(1'b1, 3'h3, 8'h00);
    chk_out(1'b1, 3'h4, 8'h0D);
    wr_reg(rim_pkg::INMAP_ADDR, 8'hFF);
    chk_out(1'b1, 3'h4, 8'hFF);
    wr_reg(rim_pkg::REMAP_ADDR, 8'h00);
    chk_out(1'b1, 3'h4, 8'hFA);
    wr_reg(rim_pkg::INMAP_ADDR, 8'h02);
    chk_out(1'b1, 3'h4, 8'h02);
    wr_reg(rim_pkg::ON_ADDR, 8'h5A);
    chk_out(1'b1, 3'h0, 8'h5A);
    chk_out(1'b1, 3'h5, 8'h5B);
    chk_rd(rim_pkg::STATUS_ADDR, 8'h5B);
    wr_reg(rim_pkg::REMAP_ADDR, 8'h03);
    chk_out(1'b0, 3'h7, 8'h00);
    wr_reg(rim_pkg::ON_ADDR, 8'hFF);
    chk_rd(rim_pkg::ON_ADDR, 8'h00);
    chk_out(1'b1, 3'h0, 8'h00);
    chk_rd(rim_pkg::ON_ADDR, 8'h00);
    chk_rd(rim_pkg::INMAP_ADDR, 8'h08);
    chk_rd(rim_pkg::REMAP_ADDR, 8'h00);
    wr_reg(rim_pkg::STATUS_ADDR, 8'hFF);
    chk_rd(rim_pkg::STATUS_ADDR, 8'h00);
    wrap_up;
  end
endmodule // relay_input_mapping_reset_tb
`default_nettype wire

// File: rim_chan.sv
`timescale 1ns/1ns
`default_nettype none
module rim_chan #(
  parameter int IDX = 0
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  rim_chan_if.chan bus
);
  logic drive;
  logic next_drive;
  logic pin_ctrl;

  always_comb begin
    // Direct pin or mappable input, never both
    pin_ctrl = bus.use_direct[IDX] ? bus.direct_pin[IDX]
                                   : (bus.map_en[IDX] & bus.mapped_pin);
    // Pin high acts like a serial on command
    next_drive = (bus.on_bit[IDX] | pin_ctrl) & ~bus.standby;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      drive <= 1'b0;
    end else begin
      drive <= next_drive;
    end
  end

  assign bus.drive[IDX] = drive;
endmodule // rim_chan
`default_nettype wire

// File: rim_chan_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rim_chan_if #(
  parameter int CH_COUNT = 8
);
  logic [CH_COUNT-1:0] on_bit;
  logic [CH_COUNT-1:0] use_direct;
  logic [CH_COUNT-1:0] map_en;
  logic [CH_COUNT-1:0] direct_pin;
  logic mapped_pin;
  logic standby;
  // One bit from each channel instance, so a net rather than a variable
  wire logic [CH_COUNT-1:0] drive;
  modport ctrl (
    output on_bit, use_direct, map_en, direct_pin, mapped_pin, standby,
    input drive
  );
  modport chan (
    input on_bit, use_direct, map_en, direct_pin, mapped_pin, standby,
    output drive
  );
endinterface
`default_nettype wire

// File: rim_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rim_host_model (
  input wire logic core_clk_in,
  output logic rst_n_out,
  output logic [2:0] pins_out
);
  // Bit 0 direct ch0, bit 1 direct ch2, bit 2 mappable
  initial begin
    rst_n_out = 1'b1;
    pins_out = 3'h0;
  end
  // Host moves pins just after an edge so sampling never races
  task automatic drive(input logic rst_n, input logic [2:0] pins);
    @(posedge core_clk_in);
    rst_n_out <= rst_n;
    pins_out <= pins;
  endtask
endmodule // rim_host_model
`default_nettype wire

// File: rim_pkg.sv
`default_nettype none
package rim_pkg;
  localparam int CH_COUNT = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ON_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] INMAP_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] REMAP_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h3;
  localparam logic [DATA_W-1:0] ON_RESET = 8'h00;
  // Mappable input drives channel 3 only after reset
  localparam logic [DATA_W-1:0] INMAP_RESET = 8'h08;
  localparam logic [1:0] REMAP_RESET = 2'h0;
  localparam int REMAP_CH0_BIT = 0;
  localparam int REMAP_CH2_BIT = 1;
  localparam int DIRECT_CH0 = 0;
  localparam int DIRECT_CH2 = 2;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
endpackage
`default_nettype wire

// File: rim_top.sv
`timescale 1ns/1ns
`default_nettype none
module rim_top #(
  parameter int CH_COUNT = rim_pkg::CH_COUNT
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic rst_n_in,
  input wire logic direct_input_ch0_in,
  input wire logic direct_input_ch2_in,
  input wire logic mappable_input_in,
  input wire logic [rim_pkg::ADDR_W-1:0] addr_in,
  input wire logic [rim_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [rim_pkg::DATA_W-1:0] rd_data_out,
  output logic [CH_COUNT-1:0] switch_output_out
);
  logic [CH_COUNT-1:0] on_reg;
  logic [CH_COUNT-1:0] inmap_reg;
  logic [1:0] remap_reg;
  logic [rim_pkg::DATA_W-1:0] rd_data;
  logic [CH_COUNT-1:0] next_on_reg;
  logic [CH_COUNT-1:0] next_inmap_reg;
  logic [1:0] next_remap_reg;
  logic [rim_pkg::DATA_W-1:0] next_rd_data;
  logic ch0_remap_flag;
  logic ch2_remap_flag;
  logic [CH_COUNT-1:0] direct_mask;

  rim_chan_if #(.CH_COUNT(CH_COUNT)) chan_bus ();

  assign ch0_remap_flag = remap_reg[rim_pkg::REMAP_CH0_BIT];
  assign ch2_remap_flag = remap_reg[rim_pkg::REMAP_CH2_BIT];

  // Map bits of the direct channels are stored but never steer a pin
  always_comb begin
    direct_mask = '0;
    direct_mask[rim_pkg::DIRECT_CH0] = 1'b1;
    direct_mask[rim_pkg::DIRECT_CH2] = 1'b1;
  end

  always_comb begin
    next_on_reg = on_reg;
    next_inmap_reg = inmap_reg;
    next_remap_reg = remap_reg;
    next_rd_data = rim_pkg::READ_IDLE;
    if (!rst_n_in) begin
      // Pin reset wins over any write in flight
      next_on_reg = rim_pkg::ON_RESET;
      next_inmap_reg = rim_pkg::INMAP_RESET;
      next_remap_reg = rim_pkg::REMAP_RESET;
    end else if (wr_in) begin
      unique case (addr_in)
        rim_pkg::ON_ADDR: next_on_reg = wr_data_in;
        rim_pkg::INMAP_ADDR: next_inmap_reg = wr_data_in;
        rim_pkg::REMAP_ADDR: next_remap_reg = wr_data_in[1:0];
        default: ;
      endcase
    end
    if (rd_in) begin
      unique case (addr_in)
        rim_pkg::ON_ADDR: next_rd_data = on_reg;
        rim_pkg::INMAP_ADDR: next_rd_data = inmap_reg;
        rim_pkg::REMAP_ADDR: next_rd_data = {6'h00, remap_reg};
        rim_pkg::STATUS_ADDR: next_rd_data = switch_output_out;
        default: next_rd_data = rim_pkg::READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      on_reg <= rim_pkg::ON_RESET;
      inmap_reg <= rim_pkg::INMAP_RESET;
      remap_reg <= rim_pkg::REMAP_RESET;
      rd_data <= rim_pkg::READ_IDLE;
    end else begin
      on_reg <= next_on_reg;
      inmap_reg <= next_inmap_reg;
      remap_reg <= next_remap_reg;
      rd_data <= next_rd_data;
    end
  end

  always_comb begin
    chan_bus.on_bit = on_reg;
    chan_bus.mapped_pin = mappable_input_in;
    // Standby keeps every stage off while the pin is low
    chan_bus.standby = ~rst_n_in;
    chan_bus.direct_pin = '0;
    chan_bus.direct_pin[rim_pkg::DIRECT_CH0] = direct_input_ch0_in;
    chan_bus.direct_pin[rim_pkg::DIRECT_CH2] = direct_input_ch2_in;
    // Channels without a direct pin use the per-channel map bit
    chan_bus.use_direct = '0;
    chan_bus.map_en = inmap_reg;
    chan_bus.use_direct[rim_pkg::DIRECT_CH0] = ~ch0_remap_flag;
    chan_bus.map_en[rim_pkg::DIRECT_CH0] = ch0_remap_flag;
    chan_bus.use_direct[rim_pkg::DIRECT_CH2] = ~ch2_remap_flag;
    chan_bus.map_en[rim_pkg::DIRECT_CH2] = ch2_remap_flag;
  end

  for (genvar i = 0; i < CH_COUNT; i++) begin : g_chan
    rim_chan #(.IDX(i)) u_chan (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .bus(chan_bus.chan)
    );
  end

  assign switch_output_out = chan_bus.drive;
  assign rd_data_out = rd_data;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence on_write_s;
    wr_in && rst_n_in && addr_in == rim_pkg::ON_ADDR;
  endsequence
  sequence steady_run_s;
    rst_n_in ##1 rst_n_in;
  endsequence

  por_defaults_a: assert property (disable iff (1'b0)
    $fell(sys_rst_in) |-> on_reg == rim_pkg::ON_RESET &&
      inmap_reg == rim_pkg::INMAP_RESET && remap_reg == rim_pkg::REMAP_RESET)
    else $error("registers not at defaults after power-on reset");
  pin_reset_a: assert property (
    !rst_n_in |=> on_reg == rim_pkg::ON_RESET &&
      inmap_reg == rim_pkg::INMAP_RESET &&
      remap_reg == rim_pkg::REMAP_RESET && switch_output_out == '0)
    else $error("reset pin did not force defaults");
  ch0_direct_a: assert property (
    (rst_n_in && !ch0_remap_flag && !on_reg[0])
      |=> switch_output_out[0] == $past(direct_input_ch0_in))
    else $error("channel 0 not following its direct pin");
  ch0_remap_a: assert property (
    (rst_n_in && ch0_remap_flag && !on_reg[0])
      |=> switch_output_out[0] == $past(mappable_input_in))
    else $error("remapped channel 0 not following mappable pin");
  ch2_select_a: assert property (
    (rst_n_in && !on_reg[2]) |=> switch_output_out[2] ==
      ($past(ch2_remap_flag) ? $past(mappable_input_in)
                             : $past(direct_input_ch2_in)))
    else $error("channel 2 source selection wrong");
  ch3_default_a: assert property (disable iff (1'b0)
    ($fell(sys_rst_in) && rst_n_in && !wr_in) |=> inmap_reg[3])
    else $error("mappable pin not on channel 3 after reset");
  map_any_a: assert property (
    (rst_n_in && mappable_input_in && (inmap_reg & ~direct_mask) != '0)
      |=> (switch_output_out & $past(inmap_reg) & ~direct_mask) ==
          ($past(inmap_reg) & ~direct_mask))
    else $error("mapped channel not driven by mappable pin");
  unmapped_off_a: assert property (
    (rst_n_in && !on_reg[1] && !inmap_reg[1]) |=> !switch_output_out[1])
    else $error("unmapped channel 1 switched on");
  on_write_a: assert property (
    on_write_s ##1 steady_run_s |-> ((switch_output_out &
      $past(wr_data_in, 2)) == $past(wr_data_in, 2)))
    else $error("serial on bit did not switch channel");
  pin_on_a: assert property (
    (rst_n_in && mappable_input_in && inmap_reg[3]) |=> switch_output_out[3])
    else $error("mapped pin high did not turn channel on");

  sequence status_read_s;
    rd_in && addr_in == rim_pkg::STATUS_ADDR;
  endsequence
  sequence on_read_s;
    rd_in && addr_in == rim_pkg::ON_ADDR;
  endsequence
  sequence inmap_read_s;
    rd_in && addr_in == rim_pkg::INMAP_ADDR;
  endsequence
  sequence inmap_write_s;
    wr_in && rst_n_in && addr_in == rim_pkg::INMAP_ADDR;
  endsequence

  on_store_a: assert property (
    on_write_s |=> on_reg == $past(wr_data_in))
    else $error("on/off write not stored");
  inmap_store_a: assert property (
    inmap_write_s |=> inmap_reg == $past(wr_data_in))
    else $error("input map write not stored");
  status_ro_a: assert property (
    (wr_in && rst_n_in && addr_in == rim_pkg::STATUS_ADDR)
      |=> $stable(on_reg) && $stable(inmap_reg) && $stable(remap_reg))
    else $error("write to status register changed a register");
  // Read data are registered and stand for one cycle only
  on_read_a: assert property (
    on_read_s |=> rd_data_out == $past(on_reg))
    else $error("on/off bits read back wrong");
  inmap_read_a: assert property (
    inmap_read_s |=> rd_data_out == $past(inmap_reg))
    else $error("input map read back wrong");
  status_read_a: assert property (
    status_read_s |=> rd_data_out == $past(switch_output_out))
    else $error("status read does not show channel state");
  bad_addr_read_a: assert property (
    (rd_in && addr_in > rim_pkg::STATUS_ADDR)
      |=> rd_data_out == rim_pkg::READ_IDLE)
    else $error("unmapped address read not idle");
  rd_idle_a: assert property (
    !rd_in |=> rd_data_out == rim_pkg::READ_IDLE)
    else $error("read data not idle outside a read");
  ch1_serial_a: assert property (
    (rst_n_in && on_reg[1]) |=> switch_output_out[1])
    else $error("channel 1 ignores its serial on bit");
  pins_isolated_a: assert property (
    (rst_n_in && !mappable_input_in) |=> (switch_output_out & ~direct_mask)
      == ($past(on_reg) & ~direct_mask))
    else $error("channel without direct pin followed another pin");
endmodule // rim_top
`default_nettype wire
